// ---- verif/apdly_aperture_delay_adjust_test.sv ----
// Self-checking bench for the aperture delay adjust block
module apdly_aperture_delay_adjust_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic                      clk_sys = 1'b0;
   logic                      rst;
   logic                      reg_wr;
   logic                      reg_rd;
   logic [11:0]               reg_addr;
   logic [7:0]                reg_wdata;
   logic [7:0]                reg_rdata;
   logic                      reg_rvalid;
   logic                      delay_cal_enable;
   logic                      cal_seq_done;
   apdly_pkg::apdly_setting_t cal_seq_result;
   logic                      cal_start;
   logic                      delay_cal_complete;
   apdly_pkg::apdly_setting_t applied_delay;
   int                        miscompares = 0;
   int                        comparisons = 0;

   always #2.5 clk_sys = ~clk_sys;

   apdly_aperture_delay_adjust u_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .delay_cal_enable(delay_cal_enable), .cal_seq_done(cal_seq_done), .cal_seq_result(cal_seq_result),
      .cal_start(cal_start), .delay_cal_complete(delay_cal_complete), .applied_delay(applied_delay));

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask

   // Read data stands for one cycle only, so it is judged at the first falling edge
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      check("read valid", reg_rvalid, 1'b1);
      check("read data", reg_rdata, exp);
   endtask

   // Free-running tick: the first step may come early, later ones are spaced exactly
   task automatic ramp_steps(input logic [7:0] step, input int n);
      logic [7:0] prev;
      int         cyc;
      for (int k = 0; k < n; k++) begin
         prev = applied_delay.coarse;
         cyc  = 0;
         while (applied_delay.coarse === prev && cyc < 800) begin
            @(negedge clk_sys);
            cyc++;
         end
         check("ramp coarse", applied_delay.coarse, 8'(prev + step));
         if (k > 0) check("ramp period", cyc, 384);
      end
   endtask

   task automatic test_reset();
      for (int i = 0; i < 8; i++) rd(12'h2B2 + 12'(i), 8'h00);
      $display("test reset done");
   endtask

   task automatic test_manual();
      int n;
      wr(12'h2B5, 8'h12);
      @(negedge clk_sys);
      check("fine applied", applied_delay.fine, 8'h12);
      wr(12'h2B7, 8'hFF);
      rd(12'h2B7, 8'h01);
      for (n = 0; n < 400 && applied_delay.inv !== 1'b1; n++) @(negedge clk_sys);
      check("invert applied", applied_delay.inv, 1'b1);
      wr(12'h2B6, 8'h20);
      for (n = 0; n < 1536 && applied_delay.coarse !== 8'h20; n++) @(negedge clk_sys);
      check("coarse applied", applied_delay.coarse, 8'h20);
      wr(12'h2B3, 8'hFF);
      rd(12'h2B3, 8'h00);
      $display("test manual done");
   endtask

   task automatic test_ramp();
      wr(12'h2B8, 8'h01);
      wr(12'h2B6, 8'h23);
      ramp_steps(8'h01, 3);
      wr(12'h2B8, 8'hFF);
      rd(12'h2B8, 8'h03);
      wr(12'h2B6, 8'h2B);
      ramp_steps(8'h04, 2);
      wr(12'h2B6, 8'h29);
      ramp_steps(8'hFE, 1);
      $display("test ramp done");
   endtask

   task automatic test_cal();
      int n;
      cal_seq_result = '{inv: 1'b1, coarse: 8'h5A, fine: 8'hA5};
      @(negedge clk_sys);
      cal_seq_done = 1'b1;
      @(negedge clk_sys);
      cal_seq_done = 1'b0;
      @(negedge clk_sys);
      check("complete idle", delay_cal_complete, 1'b0);
      delay_cal_enable = 1'b1;
      for (n = 0; n < 3 && cal_start !== 1'b1; n++) @(negedge clk_sys);
      check("start pulse", cal_start, 1'b1);
      @(negedge clk_sys);
      check("start ends", cal_start, 1'b0);
      check("complete running", delay_cal_complete, 1'b0);
      cal_seq_done = 1'b1;
      @(negedge clk_sys);
      cal_seq_done = 1'b0;
      for (n = 0; n < 2 && delay_cal_complete !== 1'b1; n++) @(negedge clk_sys);
      check("complete set", delay_cal_complete, 1'b1);
      rd(12'h2B2, 8'hA5);
      rd(12'h2B3, 8'h5A);
      rd(12'h2B4, 8'h03);
      check("cal applied", applied_delay, 17'h15AA5);
      wr(12'h2B5, 8'h77);
      repeat (2) @(negedge clk_sys);
      check("manual ignored", applied_delay.fine, 8'hA5);
      delay_cal_enable = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("complete cleared", delay_cal_complete, 1'b0);
      check("manual back", applied_delay.fine, 8'h77);
      $display("test cal done");
   endtask

   initial begin
      rst              = 1'b1;
      reg_wr           = 1'b0;
      reg_rd           = 1'b0;
      reg_addr         = 12'h000;
      reg_wdata        = 8'h00;
      delay_cal_enable = 1'b0;
      cal_seq_done     = 1'b0;
      cal_seq_result   = apdly_pkg::SETTING_RESET;
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      test_reset();
      test_manual();
      test_ramp();
      test_cal();
      give_verdict();
   end
endmodule // apdly_aperture_delay_adjust_test

// ---- verilog/apdly_aperture_delay_adjust.sv ----
// Aperture delay adjust: status, manual adjust, coarse ramp and applied delay
module apdly_aperture_delay_adjust (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [apdly_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [apdly_pkg::DATA_W-1:0] reg_wdata,
   output logic      [apdly_pkg::DATA_W-1:0] reg_rdata,
   output logic                              reg_rvalid,
   input  wire logic                         delay_cal_enable,
   input  wire logic                         cal_seq_done,
   input  wire apdly_pkg::apdly_setting_t    cal_seq_result,
   output logic                              cal_start,
   output logic                              delay_cal_complete,
   output apdly_pkg::apdly_setting_t         applied_delay
);

   function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt,
                                               input logic [7:0] step);
      logic [7:0] diff;
      diff = 8'h00;
      if (tgt > cur) begin
         diff = tgt - cur;
         step_toward = (diff > step) ? 8'(cur + step) : tgt;
      end else begin
         diff = cur - tgt;
         step_toward = (diff > step) ? 8'(cur - step) : tgt;
      end
   endfunction

   function automatic logic [7:0] pick_byte(input logic [23:0] word, input logic [1:0] idx);
      unique case (idx)
         2'h0:    pick_byte = word[7:0];
         2'h1:    pick_byte = word[15:8];
         2'h2:    pick_byte = word[23:16];
         default: pick_byte = 8'h00;
      endcase
   endfunction

   // Software visible state
   apdly_pkg::apdly_setting_t adjust_reg, adjust_next;
   logic [1:0]                ramp_ctrl_reg, ramp_ctrl_next;
   logic [7:0]                rdata_next;
   logic                      rvalid_next;
   logic [23:0]               status_word;
   logic [23:0]               adjust_word;

   // Calibration tracking
   apdly_pkg::apdly_cal_state_t cal_state_reg, cal_state_next;
   apdly_pkg::apdly_setting_t   result_reg, result_next;
   logic                        cal_en_d_reg, cal_en_d_next;
   logic                        cal_start_next;
   logic                        complete_next;

   // Coarse ramp and applied delay
   logic [8:0]                tick_cnt_reg, tick_cnt_next;
   logic                      tick;
   logic [7:0]                coarse_cur_reg, coarse_cur_next;
   apdly_pkg::apdly_setting_t applied_next;

   assign tick = (tick_cnt_reg == apdly_pkg::TICK_LAST);

   assign status_word = {6'h00, delay_cal_complete, result_reg}; // [RULE_02] [RULE_04] [RULE_05] [RULE_18]
   assign adjust_word = {7'h00, adjust_reg};                     // [RULE_18]

   // Register access
   always_comb begin
      adjust_next    = adjust_reg;
      ramp_ctrl_next = ramp_ctrl_reg;
      rdata_next     = 8'h00;
      rvalid_next    = reg_rd;
      if (reg_wr) begin
         if (reg_addr == apdly_pkg::ADJUST_ADDR) begin
            adjust_next.fine = reg_wdata; // [RULE_09]
         end else if (reg_addr == 12'(apdly_pkg::ADJUST_ADDR + 12'h001)) begin
            adjust_next.coarse = reg_wdata;
         end else if (reg_addr == 12'(apdly_pkg::ADJUST_ADDR + 12'h002)) begin
            adjust_next.inv = reg_wdata[0]; // [RULE_18]
         end else if (reg_addr == apdly_pkg::RAMP_CTRL_ADDR) begin
            ramp_ctrl_next = reg_wdata[1:0]; // [RULE_18]
         end
      end
      if (reg_rd) begin
         if (reg_addr >= apdly_pkg::CAL_RESULT_ADDR && reg_addr < apdly_pkg::ADJUST_ADDR) begin
            rdata_next = pick_byte(status_word, 2'(reg_addr - apdly_pkg::CAL_RESULT_ADDR));
         end else if (reg_addr >= apdly_pkg::ADJUST_ADDR && reg_addr < apdly_pkg::RAMP_CTRL_ADDR) begin
            rdata_next = pick_byte(adjust_word, 2'(reg_addr - apdly_pkg::ADJUST_ADDR));
         end else if (reg_addr == apdly_pkg::RAMP_CTRL_ADDR) begin
            rdata_next = {6'h00, ramp_ctrl_reg};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         adjust_reg    <= apdly_pkg::SETTING_RESET;
         ramp_ctrl_reg <= apdly_pkg::RAMP_RESET;
         reg_rdata     <= 8'h00;
         reg_rvalid    <= 1'b0;
      end else begin
         adjust_reg    <= adjust_next;
         ramp_ctrl_reg <= ramp_ctrl_next;
         reg_rdata     <= rdata_next;
         reg_rvalid    <= rvalid_next;
      end
   end

   // Calibration start, completion and result capture
   always_comb begin
      cal_state_next = cal_state_reg;
      result_next    = result_reg;
      cal_en_d_next  = delay_cal_enable;
      cal_start_next = delay_cal_enable && !cal_en_d_reg; // [RULE_16]
      unique case (cal_state_reg)
         apdly_pkg::APDLY_CAL_IDLE: begin
            if (cal_start_next) begin
               cal_state_next = apdly_pkg::APDLY_CAL_RUN;
            end
         end
         apdly_pkg::APDLY_CAL_RUN: begin
            if (!delay_cal_enable) begin
               cal_state_next = apdly_pkg::APDLY_CAL_IDLE;
            end else if (cal_seq_done) begin
               cal_state_next = apdly_pkg::APDLY_CAL_DONE;
               result_next    = cal_seq_result; // [RULE_02]
            end
         end
         apdly_pkg::APDLY_CAL_DONE: begin
            if (!delay_cal_enable) begin
               cal_state_next = apdly_pkg::APDLY_CAL_IDLE;
            end
         end
         default: cal_state_next = apdly_pkg::APDLY_CAL_IDLE;
      endcase
      // Done only while enabled and finished; dropping the enable clears it at the next clock
      complete_next = delay_cal_enable && (cal_state_next == apdly_pkg::APDLY_CAL_DONE); // [RULE_01]
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cal_state_reg      <= apdly_pkg::APDLY_CAL_IDLE;
         result_reg         <= apdly_pkg::SETTING_RESET;
         cal_en_d_reg       <= 1'b0;
         cal_start          <= 1'b0;
         delay_cal_complete <= 1'b0;
      end else begin
         cal_state_reg      <= cal_state_next;
         result_reg         <= result_next;
         cal_en_d_reg       <= cal_en_d_next;
         cal_start          <= cal_start_next;
         delay_cal_complete <= complete_next;
      end
   end

   // Coarse ramp; updating only on the tick bounds the settle time well inside the limit
   always_comb begin
      tick_cnt_next   = tick ? 9'h000 : 9'(tick_cnt_reg + 9'h001);
      coarse_cur_next = coarse_cur_reg;
      if (tick) begin
         if (ramp_ctrl_reg[apdly_pkg::RAMP_EN_BIT]) begin
            coarse_cur_next = step_toward(coarse_cur_reg, adjust_reg.coarse,
                                          ramp_ctrl_reg[apdly_pkg::RAMP_RATE_BIT] ?
                                          apdly_pkg::STEP_FAST : apdly_pkg::STEP_SLOW); // [RULE_14] [RULE_12]
         end else begin
            coarse_cur_next = adjust_reg.coarse; // [RULE_15]
         end
      end
      if (delay_cal_enable) begin
         applied_next = result_reg; // [RULE_17]
      end else begin
         applied_next.inv    = adjust_reg.inv;    // [RULE_06]
         applied_next.coarse = coarse_cur_reg;    // [RULE_07]
         applied_next.fine   = adjust_reg.fine;   // [RULE_08] [RULE_09]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tick_cnt_reg   <= 9'h000;
         coarse_cur_reg <= apdly_pkg::COARSE_RESET;
         applied_delay  <= apdly_pkg::SETTING_RESET;
      end else begin
         tick_cnt_reg   <= tick_cnt_next;
         coarse_cur_reg <= coarse_cur_next;
         applied_delay  <= applied_next;
      end
   end

   // Checks
   // Check-only counters: long spans are asserted on a count, not on a deep delay
   logic [8:0]  tick_gap_reg, tick_gap_next;
   logic [10:0] pend_cnt_reg, pend_cnt_next;
   logic        pend_clear;

   assign pend_clear = ramp_ctrl_reg[apdly_pkg::RAMP_EN_BIT] || (coarse_cur_reg == adjust_reg.coarse);

   always_comb begin
      tick_gap_next = tick ? 9'h000 : 9'(tick_gap_reg + 9'h001);
      pend_cnt_next = pend_clear ? 11'h000 : 11'(pend_cnt_reg + 11'h001);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tick_gap_reg <= 9'h000;
         pend_cnt_reg <= 11'h000;
      end else begin
         tick_gap_reg <= tick_gap_next;
         pend_cnt_reg <= pend_cnt_next;
      end
   end

   sequence s_fine_write;
      (reg_wr && reg_addr == apdly_pkg::ADJUST_ADDR) ##1 !delay_cal_enable;
   endsequence

   sequence s_cal_rise;
      delay_cal_enable && !cal_en_d_reg;
   endsequence

   sequence s_start_pulse;
      cal_start ##1 !cal_start;
   endsequence

   a_cal_start_edge: assert property (@(posedge clk_sys) disable iff (rst)
      s_cal_rise |=> s_start_pulse) else $error("calibration start not pulsed on enable rise"); // [RULE_16]

   a_done_needs_enable: assert property (@(posedge clk_sys) disable iff (rst)
      delay_cal_complete |-> $past(delay_cal_enable)) else $error("done set while calibration disabled"); // [RULE_01]

   a_done_after_seq: assert property (@(posedge clk_sys) disable iff (rst)
      (cal_state_reg == apdly_pkg::APDLY_CAL_RUN && delay_cal_enable && cal_seq_done) |=>
      (delay_cal_complete && result_reg == $past(cal_seq_result))) else $error("result not captured on done"); // [RULE_02]

   a_status_layout: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == 12'(apdly_pkg::CAL_RESULT_ADDR + 12'h002)) |=>
      (reg_rvalid && reg_rdata == {6'h00, $past(delay_cal_complete), $past(result_reg.inv)}))
      else $error("status high byte wrong"); // [RULE_04] [RULE_18]

   a_cal_overrides: assert property (@(posedge clk_sys) disable iff (rst)
      delay_cal_enable |=> applied_delay == $past(result_reg)) else $error("manual setting used during cal"); // [RULE_17]

   a_manual_apply: assert property (@(posedge clk_sys) disable iff (rst)
      !delay_cal_enable |=> (applied_delay.fine == $past(adjust_reg.fine) &&
      applied_delay.inv == $past(adjust_reg.inv) && applied_delay.coarse == $past(coarse_cur_reg)))
      else $error("manual setting not applied"); // [RULE_06] [RULE_08] [RULE_09]

   a_coarse_on_tick: assert property (@(posedge clk_sys) disable iff (rst)
      (coarse_cur_reg != $past(coarse_cur_reg)) |-> $past(tick)) else $error("coarse moved off tick"); // [RULE_14]

   a_ramp_step: assert property (@(posedge clk_sys) disable iff (rst)
      ($past(tick) && $past(ramp_ctrl_reg[apdly_pkg::RAMP_EN_BIT])) |->
      ((coarse_cur_reg >= $past(coarse_cur_reg) ? coarse_cur_reg - $past(coarse_cur_reg) :
      $past(coarse_cur_reg) - coarse_cur_reg) <= ($past(ramp_ctrl_reg[apdly_pkg::RAMP_RATE_BIT]) ? 8'h04 : 8'h01)))
      else $error("ramp step too large"); // [RULE_14] [RULE_12]

   a_direct_apply: assert property (@(posedge clk_sys) disable iff (rst)
      (tick && !ramp_ctrl_reg[apdly_pkg::RAMP_EN_BIT]) |=> coarse_cur_reg == $past(adjust_reg.coarse))
      else $error("coarse not applied on tick"); // [RULE_07] [RULE_15]

   a_tick_period: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14] [RULE_15]
      (tick_gap_reg == apdly_pkg::TICK_LAST) |-> tick) else $error("tick period not 384");

   a_tick_spacing: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
      tick |-> (tick_gap_reg == apdly_pkg::TICK_LAST)) else $error("tick came early");

   a_apply_deadline: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_15]
      pend_cnt_reg < 11'(apdly_pkg::APPLY_MAX_CYC)) else $error("coarse write not applied in time");

   a_start_only_rise: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
      !(delay_cal_enable && !cal_en_d_reg) |=> !cal_start) else $error("calibration start without enable rise");

   a_done_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_01]
      !delay_cal_enable |=> !delay_cal_complete) else $error("done kept after calibration disabled");

   a_result_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02]
      !(cal_state_reg == apdly_pkg::APDLY_CAL_RUN && delay_cal_enable && cal_seq_done) |=> $stable(result_reg))
      else $error("result changed without sequence done");

   a_fine_write: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_09]
      s_fine_write |=> applied_delay.fine == $past(reg_wdata, 2)) else $error("fine write not applied");

   a_result_fine_read: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
      (reg_rd && reg_addr == apdly_pkg::CAL_RESULT_ADDR) |=>
      reg_rdata == $past(result_reg.fine)) else $error("status low byte wrong");

   a_result_coarse_read: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
      (reg_rd && reg_addr == 12'(apdly_pkg::CAL_RESULT_ADDR + 12'h001)) |=>
      reg_rdata == $past(result_reg.coarse)) else $error("status middle byte wrong");

   a_coarse_reg_read: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_07]
      (reg_rd && reg_addr == 12'(apdly_pkg::ADJUST_ADDR + 12'h001)) |=>
      reg_rdata == $past(adjust_reg.coarse)) else $error("coarse field read wrong");

   a_inv_reserved: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_18]
      (reg_rd && reg_addr == 12'(apdly_pkg::ADJUST_ADDR + 12'h002)) |=>
      reg_rdata[7:1] == 7'h00) else $error("reserved adjust bits not zero");

   a_ramp_up: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
      (tick && ramp_ctrl_reg[apdly_pkg::RAMP_EN_BIT] && coarse_cur_reg < adjust_reg.coarse) |=>
      (coarse_cur_reg > $past(coarse_cur_reg) && coarse_cur_reg <= $past(adjust_reg.coarse)))
      else $error("ramp up did not move toward target");

   a_ramp_down: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
      (tick && ramp_ctrl_reg[apdly_pkg::RAMP_EN_BIT] && coarse_cur_reg > adjust_reg.coarse) |=>
      (coarse_cur_reg < $past(coarse_cur_reg) && coarse_cur_reg >= $past(adjust_reg.coarse)))
      else $error("ramp down did not move toward target");

endmodule // apdly_aperture_delay_adjust

// ---- verilog/apdly_pkg.sv ----
// Constants, types and register map of the aperture delay adjust block
// Functional notes
// RULE_01: Done bit set only if enabled and finished
// RULE_02: Status bits 16:0 carry calibrated delay result
// RULE_03: Software trusts result only when done reads 1
// RULE_04: Result bit 16 reports sample clock inversion
// RULE_05: Result 15:8 coarse code, 7:0 fine code
// RULE_06: Manual invert bit 16 inverts sampling clock
// RULE_07: Manual coarse field sets delay without calibration
// RULE_08: Manual fine field sets delay without calibration
// RULE_09: Fine value applies anytime without glitch
// RULE_10: Software stops calibration and link before inverting
// RULE_11: Coarse changes limited to four codes while running
// RULE_12: Small writes or hardware ramp meet step limit
// RULE_13: Software should move coarse one code per write
// RULE_14: Ramp steps one or four codes per 384 cycles
// RULE_15: Without ramp, coarse applies within 1536 cycles
// RULE_16: Rising calibration enable starts calibration sequence
// RULE_17: Calibration enabled overrides manual adjust register
// RULE_18: Reserved bits read zero, writes ignored
package apdly_pkg;

   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 8;
   // Each 24-bit register spans three byte addresses, low byte first
   localparam logic [11:0] CAL_RESULT_ADDR = 12'h2B2;
   localparam logic [11:0] ADJUST_ADDR     = 12'h2B5;
   localparam logic [11:0] RAMP_CTRL_ADDR  = 12'h2B8;

   localparam int          DONE_BIT        = 17;
   localparam int          INV_BIT         = 16;
   localparam int          COARSE_LSB      = 8;
   localparam int          RAMP_EN_BIT     = 0;
   localparam int          RAMP_RATE_BIT   = 1;

   localparam logic [7:0]  COARSE_RESET    = 8'h00;
   localparam logic [7:0]  FINE_RESET      = 8'h00;
   localparam logic [1:0]  RAMP_RESET      = 2'h0;
   localparam logic [7:0]  STEP_SLOW       = 8'h01;
   localparam logic [7:0]  STEP_FAST       = 8'h04;

   // Ramp and update tick, in clk_sys cycles
   localparam int          TICK_CYCLES     = 384;
   localparam int          APPLY_MAX_CYC   = 1536;
   localparam int          TICK_W          = 9;
   localparam logic [8:0]  TICK_LAST       = 9'(TICK_CYCLES - 1);

   typedef struct packed {
      logic       inv;
      logic [7:0] coarse;
      logic [7:0] fine;
   } apdly_setting_t;

   localparam apdly_setting_t SETTING_RESET = '{inv: 1'b0, coarse: 8'h00, fine: 8'h00};

   typedef enum logic [1:0] {
      APDLY_CAL_IDLE = 2'b00,
      APDLY_CAL_RUN  = 2'b01,
      APDLY_CAL_DONE = 2'b10
   } apdly_cal_state_t;

endpackage
